// file: core/dcf_top.sv
`timescale 1ns/10ps
module dcf_top #(
    parameter int DATA_W = dcf_pkg::DATA_W,
    parameter int ADDR_W = dcf_pkg::ADDR_W
) (
    // system
    input wire logic clock,
    input wire logic rstn,
    // resets and mode pins
    input wire logic full_reset_n,
    input wire logic partial_reset_n,
    input wire logic mode_select_serial_in,
    input wire logic serial_load_en_n,
    input wire logic offset_access_n,
    // writer side
    input wire logic write_clk,
    input wire logic write_n,
    input wire logic [DATA_W-1:0] write_data,
    // reader side
    input wire logic read_clk,
    input wire logic read_n,
    input wire logic replay_n,
    input wire logic output_drive_n,
    output logic [DATA_W-1:0] read_data_out,
    output logic read_data_oe,
    // flags
    output logic empty_flag_n,
    output logic out_ready_n,
    output logic full_flag_n,
    output logic in_space_n,
    output logic almost_empty_flag_n,
    output logic almost_full_flag_n,
    output logic half_full_flag_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    localparam int PTR_W = ADDR_W + 2;
    localparam int OFS_W = dcf_pkg::OFS_W;
    localparam logic [PTR_W-1:0] DEPTH = {2'b01, {ADDR_W{1'b0}}};
    localparam logic [PTR_W-1:0] HALF = {3'b001, {(ADDR_W-1){1'b0}}};

    ////////////////////////////////////////////////////////////////////////
    // state

    logic wclk_q;
    logic rclk_q;
    logic fall_through_q;
    logic serial_method_q;
    logic [OFS_W-1:0] empty_ofs_q;
    logic [OFS_W-1:0] full_ofs_q;
    logic [PTR_W-1:0] wptr_q;
    logic [PTR_W-1:0] rptr_q;
    logic ov_q;
    logic [PTR_W-1:0] rp_w1_q;
    logic [PTR_W-1:0] rp_w2_q;
    logic [PTR_W-1:0] wp_r1_q;
    logic [PTR_W-1:0] wp_r2_q;
    logic [DATA_W-1:0] data_q;
    logic oe_q;
    logic ef_q;
    logic or_q;
    logic ff_q;
    logic ir_q;
    logic pae_q;
    logic paf_q;
    logic hf_q;
    logic ack_q;
    logic [31:0] dat_q;

    ////////////////////////////////////////////////////////////////////////
    // decode

    wire fifo_rst_n = rstn & full_reset_n & partial_reset_n;
    wire wr_edge = write_clk & ~wclk_q;
    wire rd_edge = read_clk & ~rclk_q;
    wire ft = fall_through_q;
    wire [PTR_W-1:0] ft_ext = {{(PTR_W-1){1'b0}}, ft};
    wire [PTR_W-1:0] ov_ext = {{(PTR_W-1){1'b0}}, ov_q};
    // the word parked in the output register still occupies a slot
    wire [PTR_W-1:0] cap = DEPTH + ft_ext;
    wire [PTR_W-1:0] hf_lvl = HALF + ft_ext;
    wire [PTR_W-1:0] cptr = rptr_q - ov_ext;
    wire wfull = (wptr_q - rp_w2_q) >= cap;
    // while offset access is low the write strobe is ignored and stores no word
    wire wr_fire = wr_edge & ~write_n & offset_access_n & ~wfull;
    wire [PTR_W-1:0] wptr_d = wptr_q + {{(PTR_W-1){1'b0}}, wr_fire};
    // flags use the value stage two takes at this edge, so release lands two edges on
    wire [PTR_W-1:0] wcount = wptr_d - rp_w1_q;
    // compared at 32 bits so that small depths and large offsets never wrap
    wire [31:0] paf_sum = {{(32-PTR_W){1'b0}}, wcount} + {{(32-OFS_W){1'b0}}, full_ofs_q};
    wire [31:0] paf_lvl = {{(32-PTR_W){1'b0}}, cap};

    wire replay_hit = rd_edge & ~replay_n;
    wire not_empty = rptr_q != wp_r2_q;
    wire strobed = rd_edge & ~read_n & offset_access_n & replay_n;
    wire std_read = ~ft & strobed & not_empty;
    wire ft_load = ft & rd_edge & replay_n & not_empty & (~ov_q | strobed);
    wire ft_drain = ft & strobed & ov_q & ~not_empty;
    wire ram_rd = std_read | ft_load;
    wire [PTR_W-1:0] rptr_d = replay_hit ? '0 : rptr_q + {{(PTR_W-1){1'b0}}, ram_rd};
    wire ov_d = replay_hit ? 1'b0 : (ft_load ? 1'b1 : (ft_drain ? 1'b0 : ov_q));
    wire [PTR_W-1:0] cptr_d = rptr_d - {{(PTR_W-1){1'b0}}, ov_d};
    wire [PTR_W-1:0] rcount = wp_r2_q - cptr_d;
    wire [31:0] rcount_w = {{(32-PTR_W){1'b0}}, rcount};
    wire [31:0] pae_lvl = {{(32-OFS_W){1'b0}}, empty_ofs_q} + {31'h0000_0000, ft};
    wire [PTR_W-1:0] occ_d = wptr_d - cptr_d;
    wire over_half = occ_d > hf_lvl;

    wire serial_shift = wr_edge & ~serial_load_en_n & ~offset_access_n
        & serial_method_q & partial_reset_n;
    wire [DATA_W-1:0] ram_rdata;

    ////////////////////////////////////////////////////////////////////////
    // storage

    dcf_ram #(
        .DATA_W(DATA_W),
        .ADDR_W(ADDR_W)
    ) u_ram (
        .clock(clock),
        .wr_en(wr_fire),
        .wr_addr(wptr_q[ADDR_W-1:0]),
        .wr_data(write_data),
        .rd_addr(rptr_q[ADDR_W-1:0]),
        .rd_data(ram_rdata)
    );

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wclk_q <= 1'b0;
            rclk_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            wclk_q <= write_clk;
            rclk_q <= read_clk;
            oe_q <= ~output_drive_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode and offsets, untouched by partial reset

    wire bus_hit = wb_cyc_i & wb_stb_i & ~ack_q;
    wire bus_wr = bus_hit & wb_we_i & ~serial_method_q;
    wire wr_eofs = bus_wr & (wb_adr_i == dcf_pkg::ADR_EMPTY_OFS);
    wire wr_fofs = bus_wr & (wb_adr_i == dcf_pkg::ADR_FULL_OFS);

    function automatic logic [OFS_W-1:0] merge(
        input logic [OFS_W-1:0] old,
        input logic [31:0] dat,
        input logic [3:0] sel
    );
        merge = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
    endfunction : merge

    // strap capture is clocked while full reset is held
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fall_through_q <= 1'b0;
            serial_method_q <= 1'b0;
            empty_ofs_q <= dcf_pkg::OFS_DEF_PAR;
            full_ofs_q <= dcf_pkg::OFS_DEF_PAR;
        end else if (!full_reset_n) begin
            fall_through_q <= mode_select_serial_in;
            serial_method_q <= offset_access_n;
            empty_ofs_q <= offset_access_n ? dcf_pkg::OFS_DEF_SER : dcf_pkg::OFS_DEF_PAR;
            full_ofs_q <= offset_access_n ? dcf_pkg::OFS_DEF_SER : dcf_pkg::OFS_DEF_PAR;
        end else if (serial_shift) begin
            // bits enter at the top; the first one lands in empty bit 0
            {full_ofs_q, empty_ofs_q} <= {mode_select_serial_in, full_ofs_q, empty_ofs_q[OFS_W-1:1]};
        end else begin
            if (wr_eofs) begin
                empty_ofs_q <= merge(empty_ofs_q, wb_dat_i, wb_sel_i);
            end
            if (wr_fofs) begin
                full_ofs_q <= merge(full_ofs_q, wb_dat_i, wb_sel_i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write side, steps only on write-clock edges

    always_ff @(posedge clock or negedge fifo_rst_n) begin
        if (!fifo_rst_n) begin
            wptr_q <= '0;
            rp_w1_q <= '0;
            rp_w2_q <= '0;
            ff_q <= dcf_pkg::RST_FF;
            ir_q <= dcf_pkg::RST_IR;
            paf_q <= dcf_pkg::RST_PAF;
        end else if (wr_edge) begin
            wptr_q <= wptr_d;
            // a stale read pointer only delays release, never overflows
            rp_w1_q <= cptr;
            rp_w2_q <= rp_w1_q;
            ff_q <= ft | ~(wcount >= cap);
            ir_q <= ft & (wcount >= cap);
            paf_q <= ~(paf_sum >= paf_lvl);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read side, steps only on read-clock edges

    always_ff @(posedge clock or negedge fifo_rst_n) begin
        if (!fifo_rst_n) begin
            rptr_q <= '0;
            ov_q <= 1'b0;
            wp_r1_q <= '0;
            wp_r2_q <= '0;
            ef_q <= dcf_pkg::RST_EF;
            or_q <= dcf_pkg::RST_OR;
            pae_q <= dcf_pkg::RST_PAE;
        end else if (rd_edge) begin
            rptr_q <= rptr_d;
            ov_q <= ov_d;
            wp_r1_q <= wptr_q;
            wp_r2_q <= wp_r1_q;
            ef_q <= ~ft & ~replay_hit & (rptr_d != wp_r1_q);
            or_q <= ~ft | ~ov_d;
            pae_q <= ~(rcount_w <= pae_lvl);
        end
    end

    // output register clears on either reset without a clock
    always_ff @(posedge clock or negedge fifo_rst_n) begin
        if (!fifo_rst_n) begin
            data_q <= '0;
        end else if (ram_rd) begin
            data_q <= ram_rdata;
        end
    end

    // half-full: write edges only set it, read edges only clear it
    always_ff @(posedge clock or negedge fifo_rst_n) begin
        if (!fifo_rst_n) begin
            hf_q <= dcf_pkg::RST_HF;
        end else if (wr_edge & over_half) begin
            hf_q <= 1'b0;
        end else if (rd_edge & ~over_half) begin
            hf_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave: one wait state, unmapped reads give zero

    logic [31:0] status;
    always_comb begin
        status = '0;
        status[dcf_pkg::ST_EF] = ef_q;
        status[dcf_pkg::ST_OR] = or_q;
        status[dcf_pkg::ST_FF] = ff_q;
        status[dcf_pkg::ST_IR] = ir_q;
        status[dcf_pkg::ST_PAE] = pae_q;
        status[dcf_pkg::ST_PAF] = paf_q;
        status[dcf_pkg::ST_HF] = hf_q;
        status[dcf_pkg::ST_FALL_THROUGH_MODE] = fall_through_q;
        status[dcf_pkg::ST_SER] = serial_method_q;
    end

    wire [PTR_W-1:0] level = wptr_q - cptr;
    wire [31:0] rd_mux =
        (wb_adr_i == dcf_pkg::ADR_STATUS) ? status :
        (wb_adr_i == dcf_pkg::ADR_EMPTY_OFS) ? {16'h0000, empty_ofs_q} :
        (wb_adr_i == dcf_pkg::ADR_FULL_OFS) ? {16'h0000, full_ofs_q} :
        (wb_adr_i == dcf_pkg::ADR_LEVEL) ? {{(32-PTR_W){1'b0}}, level} : 32'h0000_0000;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= bus_hit;
            dat_q <= bus_hit ? rd_mux : dat_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign read_data_out = data_q;
    assign read_data_oe = oe_q;
    assign empty_flag_n = ef_q;
    assign out_ready_n = or_q;
    assign full_flag_n = ff_q;
    assign in_space_n = ir_q;
    assign almost_empty_flag_n = pae_q;
    assign almost_full_flag_n = paf_q;
    assign half_full_flag_n = hf_q;
    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!fifo_rst_n);

    sequence replay_req_s;
        rd_edge && !replay_n;
    endsequence

    sequence rewound_s;
        rptr_q == '0 && !ov_q;
    endsequence

    a_partial_reset_state: assert property (disable iff (!rstn)
        !partial_reset_n [*2] |-> wptr_q == '0 && rptr_q == '0 && !pae_q && paf_q && hf_q)
        else $error("partial reset left pointers or flags wrong");
    a_partial_keeps_cfg: assert property (disable iff (!rstn)
        !partial_reset_n && full_reset_n |=> $stable(fall_through_q)
            && $stable(empty_ofs_q) && $stable(full_ofs_q))
        else $error("partial reset disturbed mode or offsets");
    a_partial_clears_data: assert property (disable iff (!rstn)
        !partial_reset_n [*2] |-> data_q == '0)
        else $error("output register not cleared");
    a_replay_standard: assert property (
        replay_req_s and !ft |=> rewound_s ##0 !ef_q)
        else $error("standard replay did not rewind with empty low");
    a_replay_fall: assert property (
        replay_req_s and ft |=> rewound_s ##0 or_q)
        else $error("fall-through replay did not rewind with valid high");
    a_mode_capture: assert property (disable iff (!rstn)
        !full_reset_n |=> fall_through_q == $past(mode_select_serial_in))
        else $error("mode not captured at full reset");
    a_full_blocks_write: assert property (
        wr_edge && wfull |=> $stable(wptr_q))
        else $error("write accepted while full");
    a_hf_set_by_write: assert property (
        $fell(hf_q) |-> $past(wr_edge))
        else $error("half-full set without a write edge");
    a_hf_clear_by_read: assert property (
        $rose(hf_q) |-> $past(rd_edge))
        else $error("half-full cleared without a read edge");
    a_read_holds_data: assert property (
        !ft && (!rd_edge || read_n) |=> $stable(data_q))
        else $error("output register changed without a read");
    a_empty_ignores_read: assert property (
        !ft && rd_edge && replay_n && !not_empty |=> $stable(rptr_q))
        else $error("read taken while empty");
    a_serial_shift_in: assert property (disable iff (!rstn)
        serial_shift && full_reset_n |=> full_ofs_q[OFS_W-1] == $past(mode_select_serial_in))
        else $error("serial bit not shifted in");
    a_defaults_pick: assert property (disable iff (!rstn)
        !full_reset_n && offset_access_n |=> empty_ofs_q == dcf_pkg::OFS_DEF_SER && serial_method_q)
        else $error("serial defaults not chosen");
    a_drive_follows: assert property (disable iff (!rstn)
        output_drive_n |=> !read_data_oe)
        else $error("data bus driven while drive pin high");
endmodule : dcf_top

// file: core/dcf_pkg.sv
// Overview of operation
// - partial reset zeroes pointers, sets level flags
// - partial reset keeps mode, sets mode flags
// - partial reset keeps offsets and loading method
// - partial reset clears output register asynchronously
// - replay setup starts on read edge, strobes idle
// - standard replay: empty low, rewind, strobed reads
// - fall-through replay: first word appears unstrobed
// - full reset samples mode pin for flag mode
// - fall-through first word after three read edges
// - mode pin becomes serial offset input afterwards
// - write edges only update write flags, set half
// - read edges only update read flags, clear half
// - write strobe stores data unless full
// - standard full flag releases two write edges later
// - fall-through in-space releases two write edges later
// - read strobe loads output register unless empty
// - standard empty flag ignores reads, two-edge release
// - fall-through true read of last word drops valid
// - serial enable and offset access shift offsets
// - output drive low enables data bus
// - offset access at full reset picks defaults
// - fall-through capacity counts the output register
package dcf_pkg;
    localparam int DATA_W = 18;
    localparam int ADDR_W = 15;
    localparam int OFS_W = 16;
    localparam logic [OFS_W-1:0] OFS_DEF_PAR = 16'h007F;
    localparam logic [OFS_W-1:0] OFS_DEF_SER = 16'h03FF;
    // register byte addresses
    localparam logic [3:0] ADR_STATUS = 4'h0;
    localparam logic [3:0] ADR_EMPTY_OFS = 4'h4;
    localparam logic [3:0] ADR_FULL_OFS = 4'h8;
    localparam logic [3:0] ADR_LEVEL = 4'hC;
    // status field positions
    localparam int ST_EF = 0;
    localparam int ST_OR = 1;
    localparam int ST_FF = 2;
    localparam int ST_IR = 3;
    localparam int ST_PAE = 4;
    localparam int ST_PAF = 5;
    localparam int ST_HF = 6;
    localparam int ST_FALL_THROUGH_MODE = 7;
    localparam int ST_SER = 8;
    // flag values under either reset
    localparam logic RST_EF = 1'b0;
    localparam logic RST_OR = 1'b1;
    localparam logic RST_FF = 1'b1;
    localparam logic RST_IR = 1'b0;
    localparam logic RST_PAE = 1'b0;
    localparam logic RST_PAF = 1'b1;
    localparam logic RST_HF = 1'b1;
endpackage : dcf_pkg

// file: core/dcf_ram.sv
`timescale 1ns/10ps
module dcf_ram #(
    parameter int DATA_W = dcf_pkg::DATA_W,
    parameter int ADDR_W = dcf_pkg::ADDR_W
) (
    // clock
    input wire logic clock,
    // write port
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    // read port, combinational so the output register owns the timing
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_addr];
endmodule : dcf_ram

// file: dv/dcf_far.sv
`timescale 1ns/10ps
module dcf_far (
    // system
    input wire logic clock,
    input wire logic rstn,
    // requests from the bench
    input wire logic wr_go,
    input wire logic wr_en,
    input wire logic rd_go,
    input wire logic rd_en,
    input wire logic rude,
    input wire logic [dcf_pkg::DATA_W-1:0] wr_d,
    // flags seen at the fifo
    input wire logic full_flag_n,
    input wire logic in_space_n,
    input wire logic empty_flag_n,
    input wire logic out_ready_n,
    // pins into the fifo
    output logic write_clk,
    output logic write_n,
    output logic [dcf_pkg::DATA_W-1:0] write_data,
    output logic read_clk,
    output logic read_n
);
    // the flag of the unused mode sits idle, so one form serves both modes
    logic room;
    logic avail;
    assign room = full_flag_n & ~in_space_n;
    assign avail = empty_flag_n | ~out_ready_n;
    ////////////////////////////////////////////////////////////////////////////
    // clocks stand low between requests; idle data is inverted so stale words never match
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            write_clk <= 1'h0;
            write_n <= 1'h1;
            write_data <= '0;
            read_clk <= 1'h0;
            read_n <= 1'h1;
        end else begin
            write_clk <= wr_go;
            write_n <= ~(wr_go & wr_en & (room | rude));
            write_data <= wr_go ? wr_d : ~write_data;
            read_clk <= rd_go;
            read_n <= ~(rd_go & rd_en & (avail | rude));
        end
    end
endmodule : dcf_far

// file: dv/dual_clock_fifo_control_tb.sv
`timescale 1ns/10ps
module dual_clock_fifo_control_tb;
    localparam logic [31:0] SV = 32'h000A0005;
    logic clock = 1'h0;
    logic rstn = 1'h0;
    logic full_reset_n = 1'h0;
    logic partial_reset_n = 1'h1;
    logic mode_select_serial_in = 1'h0;
    logic serial_load_en_n = 1'h1;
    logic offset_access_n = 1'h0;
    logic replay_n = 1'h1;
    logic output_drive_n = 1'h0;
    logic wb_cyc_i = 1'h0;
    logic wb_stb_i = 1'h0;
    logic wb_we_i = 1'h0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic wr_go = 1'h0;
    logic wr_en = 1'h0;
    logic rd_go = 1'h0;
    logic rd_en = 1'h0;
    logic rude = 1'h0;
    logic [17:0] wr_d = 18'h0;
    logic write_clk, write_n, read_clk, read_n, read_data_oe, wb_ack_o;
    logic [17:0] write_data, read_data_out;
    logic [31:0] wb_dat_o;
    logic empty_flag_n, out_ready_n, full_flag_n, in_space_n;
    logic almost_empty_flag_n, almost_full_flag_n, half_full_flag_n;
    logic [17:0] mem [17];
    integer seed = 32'hCABDD398;
    int num_errors = 0;
    int n_compared = 0;
    always #50 clock = ~clock;
    dcf_top #(.ADDR_W(4)) dut (.clock, .rstn, .full_reset_n, .partial_reset_n,
        .mode_select_serial_in, .serial_load_en_n, .offset_access_n, .write_clk, .write_n,
        .write_data, .read_clk, .read_n, .replay_n, .output_drive_n, .read_data_out,
        .read_data_oe, .empty_flag_n, .out_ready_n, .full_flag_n, .in_space_n,
        .almost_empty_flag_n, .almost_full_flag_n, .half_full_flag_n, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o);
    dcf_far far (.clock, .rstn, .wr_go, .wr_en, .rd_go, .rd_en, .rude, .wr_d, .full_flag_n,
        .in_space_n, .empty_flag_n, .out_ready_n, .write_clk, .write_n, .write_data,
        .read_clk, .read_n);
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [6:0] flg();
        return {half_full_flag_n, almost_full_flag_n, almost_empty_flag_n, in_space_n,
            full_flag_n, out_ready_n, empty_flag_n};
    endfunction : flg
    function automatic logic [31:0] st_exp(input logic ft, input logic ser, input logic [6:0] f);
        return {23'h0, ser, ft, f};
    endfunction : st_exp
    task report_and_stop;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        @(posedge clock);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (wb_ack_o !== 1'h1 && k < 50);
        if (k >= 50) begin
            num_errors++;
            report_and_stop();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask : wb
    task rd_chk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'h0, a, 32'h0, q);
        chk(q, e);
    endtask : rd_chk
    // one write or read clock pulse, high for a single system clock
    task pulse(input logic w, input logic en, input logic [17:0] d);
        @(posedge clock);
        wr_go <= w;
        rd_go <= ~w;
        wr_en <= en;
        rd_en <= en;
        wr_d <= d;
        @(posedge clock);
        wr_go <= 1'h0;
        rd_go <= 1'h0;
        repeat (2) @(posedge clock);
    endtask : pulse
    task wait_rdy;
        int k;
        for (k = 0; k < 8 && (empty_flag_n | ~out_ready_n) !== 1'h1; k++)
            pulse(1'h0, 1'h0, 18'h0);
        if (k == 8) begin
            num_errors++;
            report_and_stop();
        end
    endtask : wait_rdy
    task freset(input logic ft, input logic ser);
        @(posedge clock);
        mode_select_serial_in <= ft;
        offset_access_n <= ser;
        full_reset_n <= 1'h0;
        repeat (3) @(posedge clock);
        full_reset_n <= 1'h1;
        @(posedge clock);
        offset_access_n <= 1'h1;
        mode_select_serial_in <= 1'h0;
        @(posedge clock);
    endtask : freset
    task prst;
        @(posedge clock);
        partial_reset_n <= 1'h0;
        repeat (2) @(posedge clock);
        chk(read_data_out, 32'h0);
        partial_reset_n <= 1'h1;
        @(posedge clock);
        chk(flg(), 7'h66);
    endtask : prst
    task replay;
        replay_n <= 1'h0;
        pulse(1'h0, 1'h0, 18'h0);
        replay_n <= 1'h1;
    endtask : replay
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        logic [31:0] q;
        for (i = 0; i < 17; i++)
            mem[i] = 18'($random(seed));
        repeat (8) @(posedge clock);
        rstn <= 1'h1;
        freset(1'h0, 1'h0);
        chk(flg(), 7'h66);
        rd_chk(dcf_pkg::ADR_STATUS, st_exp(1'h0, 1'h0, 7'h66));
        rd_chk(dcf_pkg::ADR_FULL_OFS, 32'h7F);
        wb(1'h1, dcf_pkg::ADR_EMPTY_OFS, 32'h12, q);
        rd_chk(4'h1, 32'h0);
        pulse(1'h1, 1'h1, mem[0]);
        for (i = 0; i < 2; i++) begin
            pulse(1'h0, 1'h0, 18'h0);
            chk(empty_flag_n, i == 1);
        end
        pulse(1'h0, 1'h1, 18'h0);
        chk(read_data_out, mem[0]);
        rude <= 1'h1;
        pulse(1'h0, 1'h1, 18'h0);
        rude <= 1'h0;
        chk(read_data_out, mem[0]);
        prst();
        rd_chk(dcf_pkg::ADR_EMPTY_OFS, 32'h12);
        for (i = 0; i < 16; i++)
            pulse(1'h1, 1'h1, mem[i]);
        chk(full_flag_n, 1'h0);
        chk(half_full_flag_n, 1'h0);
        rude <= 1'h1;
        pulse(1'h1, 1'h1, mem[16]);
        rude <= 1'h0;
        for (i = 0; i < 3; i++)
            pulse(1'h0, i == 2, 18'h0);
        chk(read_data_out, mem[0]);
        for (i = 0; i < 2; i++) begin
            pulse(1'h1, 1'h0, 18'h0);
            chk(full_flag_n, i == 1);
        end
        for (i = 1; i < 16; i++) begin
            pulse(1'h0, 1'h1, 18'h0);
            chk(read_data_out, mem[i]);
        end
        chk(empty_flag_n, 1'h0);
        chk(half_full_flag_n, 1'h1);
        replay();
        chk(empty_flag_n, 1'h0);
        wait_rdy();
        pulse(1'h0, 1'h1, 18'h0);
        chk(read_data_out, mem[0]);
        output_drive_n <= 1'h1;
        repeat (2) @(posedge clock);
        chk(read_data_oe, 1'h0);
        output_drive_n <= 1'h0;
        repeat (2) @(posedge clock);
        chk(read_data_oe, 1'h1);
        ////////////////////////////////////////////////////////////////////////
        // fall-through mode with serial offsets
        freset(1'h1, 1'h1);
        chk(flg(), 7'h66);
        rd_chk(dcf_pkg::ADR_STATUS, st_exp(1'h1, 1'h1, 7'h66));
        rd_chk(dcf_pkg::ADR_EMPTY_OFS, 32'h3FF);
        offset_access_n <= 1'h0;
        // the last pulse carries a flipped bit with shifting disabled
        for (i = 0; i < 33; i++) begin
            serial_load_en_n <= (i == 32);
            mode_select_serial_in <= SV[i[4:0]] ^ (i == 32);
            pulse(1'h1, 1'h0, 18'h0);
        end
        offset_access_n <= 1'h1;
        wb(1'h1, dcf_pkg::ADR_EMPTY_OFS, 32'h55, q);
        rd_chk(dcf_pkg::ADR_EMPTY_OFS, {16'h0, SV[15:0]});
        rd_chk(dcf_pkg::ADR_FULL_OFS, {16'h0, SV[31:16]});
        pulse(1'h1, 1'h1, mem[0]);
        for (i = 0; i < 3; i++) begin
            pulse(1'h0, 1'h0, 18'h0);
            chk(out_ready_n, i < 2);
        end
        chk(read_data_out, mem[0]);
        for (i = 1; i < 17; i++) begin
            pulse(1'h1, 1'h1, mem[i]);
            chk(in_space_n, i == 16);
        end
        for (i = 0; i < 2; i++)
            pulse(1'h0, 1'h0, 18'h0);
        for (i = 1; i < 17; i++) begin
            pulse(1'h0, 1'h1, 18'h0);
            chk(read_data_out, mem[i]);
        end
        pulse(1'h0, 1'h1, 18'h0);
        chk(out_ready_n, 1'h1);
        chk(read_data_out, mem[16]);
        for (i = 0; i < 2; i++) begin
            pulse(1'h1, 1'h0, 18'h0);
            chk(in_space_n, i == 0);
        end
        prst();
        rd_chk(dcf_pkg::ADR_EMPTY_OFS, {16'h0, SV[15:0]});
        pulse(1'h1, 1'h1, mem[0]);
        pulse(1'h1, 1'h1, mem[1]);
        wait_rdy();
        pulse(1'h0, 1'h1, 18'h0);
        chk(read_data_out, mem[1]);
        replay();
        chk(out_ready_n, 1'h1);
        wait_rdy();
        chk(read_data_out, mem[0]);
        report_and_stop();
    end
endmodule : dual_clock_fifo_control_tb
